// [inc/rlss_params.svh]
// Constants for the radio line state sequencer: packet IDs, field positions, resets, timing
`ifndef RLSS_PARAMS_SVH
`define RLSS_PARAMS_SVH
// Packet identifiers (top byte)
`define RLSS_ID_OVERRIDE   8'h0f
`define RLSS_ID_FAST_SYNC  8'h16
`define RLSS_ID_SLOW_SYNC  8'h17
`define RLSS_ID_FAST_DATA  8'h18
`define RLSS_ID_SLOW_DATA  8'h19
`define RLSS_ID_SHUT_ONE   8'h1a
`define RLSS_ID_SHUT_TWO   8'h1b
// Field positions inside the 24-bit payload
`define RLSS_ALLOW_BIT     23
`define RLSS_PROBE_BIT     19
`define RLSS_PAT_HI        15
`define RLSS_PAT_LO        8
`define RLSS_LVL_HI        7
`define RLSS_LVL_LO        0
`define RLSS_FDWELL_HI     6
`define RLSS_SDWELL_HI     5
// Reset values
`define RLSS_PAT_RST       8'h00
`define RLSS_FDWELL_RST    7'h01
`define RLSS_SDWELL_RST    6'h01
// Timing: tick period and core clock rate
`define RLSS_TICK_US       625
`define RLSS_CLK_KHZ       10000
`define RLSS_TICK_CYC      ((`RLSS_TICK_US * `RLSS_CLK_KHZ) / 1000)
`endif

// [inc/rlss_pkg.sv]
// Types shared by the radio line state sequencer
package rlss_pkg;
   typedef enum logic [3:0] {
      RLSS_IDLE      = 4'h0,
      RLSS_OFF       = 4'h1,
      RLSS_WARM      = 4'h2,
      RLSS_SYNC_SLOW = 4'h3,
      RLSS_SYNC_FAST = 4'h4,
      RLSS_DATA_SLOW = 4'h5,
      RLSS_DATA_FAST = 4'h6,
      RLSS_SHUT_ONE  = 4'h7,
      RLSS_SHUT_TWO  = 4'h8
   } rlss_state_e;
endpackage

// [core/rlss_top.sv]
// Radio line state sequencer: active states, line override and shut-down sequence
`timescale 1ns/1ns
`include "rlss_params.svh"

module rlss_top #(
   parameter int TICK_CYCLES = `RLSS_TICK_CYC
) (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_b_i,
   // Configuration packet port
   input  wire logic       pkt_valid_i,
   input  wire logic [7:0] pkt_id_i,
   input  wire logic [23:0] pkt_data_i,
   // Decoder core status and requests
   input  wire logic       decoder_enable_i,
   input  wire logic       rate_fast_i,
   input  wire logic       warmup_done_i,
   input  wire logic [7:0] warmup_lines_i,
   input  wire logic       sync_c_found_i,
   input  wire logic       resync_i,
   input  wire logic       rx_off_req_i,
   input  wire logic [7:0] off_pattern_i,
   input  wire logic       battery_low_in_i,
   // Receiver control lines
   output logic [7:0]      radio_ctrl_lines_o,
   output logic [7:0]      radio_ctrl_oe_o,
   // Status to the decoder core
   output logic            warmup_start_o,
   output logic            dwell_done_o,
   output logic            shutdown_busy_o,
   output logic            battery_sample_o,
   output logic            battery_low_o,
   output logic [3:0]      state_o
);

   // Elaboration check: a tick shorter than two cycles leaves the counter no room
   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
   end

   localparam int TW = $clog2(TICK_CYCLES + 1);

   // Settings written by the host
   logic       fsync_probe, ssync_probe, fdata_probe, sdata_probe;
   logic [7:0] fsync_pat, ssync_pat, fdata_pat, sdata_pat;
   logic [6:0] fsync_dwell;
   logic       sd1_allow, sd2_allow, sd1_probe, sd2_probe;
   logic [7:0] sd1_pat, sd2_pat;
   logic [5:0] sd1_dwell, sd2_dwell;
   logic [7:0] ovr_en, ovr_lvl;

   // Sequencer state
   rlss_pkg::rlss_state_e state, next_state;
   logic          ever_on;
   logic          en_q;
   logic          warm_pend;
   logic [TW-1:0] tick_cnt;
   logic [6:0]    ticks;

   // Packet decode
   wire wr_ovr   = pkt_valid_i && (pkt_id_i == `RLSS_ID_OVERRIDE);
   wire wr_fsync = pkt_valid_i && (pkt_id_i == `RLSS_ID_FAST_SYNC);
   wire wr_ssync = pkt_valid_i && (pkt_id_i == `RLSS_ID_SLOW_SYNC);
   wire wr_fdata = pkt_valid_i && (pkt_id_i == `RLSS_ID_FAST_DATA);
   wire wr_sdata = pkt_valid_i && (pkt_id_i == `RLSS_ID_SLOW_DATA);
   wire wr_sd1   = pkt_valid_i && (pkt_id_i == `RLSS_ID_SHUT_ONE);
   wire wr_sd2   = pkt_valid_i && (pkt_id_i == `RLSS_ID_SHUT_TWO);
   wire       p_probe = pkt_data_i[`RLSS_PROBE_BIT];
   wire       p_allow = pkt_data_i[`RLSS_ALLOW_BIT];
   wire [7:0] p_pat   = pkt_data_i[`RLSS_PAT_HI:`RLSS_PAT_LO];
   wire [7:0] p_lvl   = pkt_data_i[`RLSS_LVL_HI:`RLSS_LVL_LO];
   wire [6:0] p_fdw   = pkt_data_i[`RLSS_FDWELL_HI:0];
   wire [5:0] p_sdw   = pkt_data_i[`RLSS_SDWELL_HI:0];

   // Register file; IDs outside the map are ignored
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         {fsync_probe, ssync_probe, fdata_probe, sdata_probe} <= 4'h0;
         {fsync_pat, ssync_pat} <= {`RLSS_PAT_RST, `RLSS_PAT_RST};
         {fdata_pat, sdata_pat} <= {`RLSS_PAT_RST, `RLSS_PAT_RST};
         fsync_dwell <= `RLSS_FDWELL_RST;
         {sd1_allow, sd2_allow, sd1_probe, sd2_probe} <= 4'h0;
         {sd1_pat, sd2_pat} <= {`RLSS_PAT_RST, `RLSS_PAT_RST};
         sd1_dwell <= `RLSS_SDWELL_RST;
         sd2_dwell <= `RLSS_SDWELL_RST;
         ovr_en  <= 8'h00;
         ovr_lvl <= 8'h00;
      end else begin
         if (wr_fsync) {fsync_probe, fsync_pat, fsync_dwell} <= {p_probe, p_pat, p_fdw};
         if (wr_ssync) {ssync_probe, ssync_pat} <= {p_probe, p_pat};
         if (wr_fdata) {fdata_probe, fdata_pat} <= {p_probe, p_pat};
         if (wr_sdata) {sdata_probe, sdata_pat} <= {p_probe, p_pat};
         if (wr_sd1) {sd1_allow, sd1_probe, sd1_pat, sd1_dwell} <=
            {p_allow, p_probe, p_pat, p_sdw};
         if (wr_sd2) {sd2_allow, sd2_probe, sd2_pat, sd2_dwell} <=
            {p_allow, p_probe, p_pat, p_sdw};
         if (wr_ovr) {ovr_en, ovr_lvl} <= {p_pat, p_lvl};
      end
   end

   // Tick and dwell timing; both restart whenever the state changes
   wire state_chg = (next_state != state);
   wire tick      = (tick_cnt == TW'(TICK_CYCLES - 1));
   wire [6:0] sd1_lim  = (sd1_dwell == 6'h00) ? 7'h01 : {1'b0, sd1_dwell};
   wire [6:0] sd2_lim  = (sd2_dwell == 6'h00) ? 7'h01 : {1'b0, sd2_dwell};
   wire [6:0] fs_lim   = (fsync_dwell == 7'h00) ? 7'h01 : fsync_dwell;
   wire sd1_done = (ticks >= sd1_lim);
   wire sd2_done = (ticks >= sd2_lim);
   wire fs_done  = (ticks >= fs_lim);

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || state_chg) begin
         tick_cnt <= '0;
         ticks    <= 7'h00;
      end else begin
         tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
         if (tick && ticks != 7'h7f) ticks <= ticks + 7'h01;           // Saturates, never wraps
      end
   end

   // Condition terms of the sequencer
   wire en_rise  = decoder_enable_i && !en_q;
   wire is_on    = (state == rlss_pkg::RLSS_SYNC_SLOW) || (state == rlss_pkg::RLSS_SYNC_FAST)
                || (state == rlss_pkg::RLSS_DATA_SLOW) || (state == rlss_pkg::RLSS_DATA_FAST);
   wire go_down  = rx_off_req_i || !decoder_enable_i;
   wire sd_first = sd1_allow ? 1'b1 : 1'b0;
   // Only an enable rise seen during shut-down asks for warm-up afterwards;
   // an off request with enable still high must end in the off pattern
   wire wake     = warm_pend || en_rise;
   wire [3:0] st_sd_entry = sd_first ? rlss_pkg::RLSS_SHUT_ONE : rlss_pkg::RLSS_OFF;

   // Next state
   always_comb begin
      next_state = state;
      case (state)
         rlss_pkg::RLSS_IDLE, rlss_pkg::RLSS_OFF: begin
            if (en_rise) next_state = rlss_pkg::RLSS_WARM;
         end
         rlss_pkg::RLSS_WARM: begin
            if (go_down) next_state = rlss_pkg::rlss_state_e'(st_sd_entry);
            else if (warmup_done_i) next_state = rate_fast_i ?
               rlss_pkg::RLSS_SYNC_FAST : rlss_pkg::RLSS_SYNC_SLOW;
         end
         rlss_pkg::RLSS_SYNC_SLOW: begin
            if (go_down) next_state = rlss_pkg::rlss_state_e'(st_sd_entry);
            else if (sync_c_found_i) next_state = rlss_pkg::RLSS_DATA_SLOW;
            else if (rate_fast_i) next_state = rlss_pkg::RLSS_SYNC_FAST;
         end
         rlss_pkg::RLSS_SYNC_FAST: begin
            if (go_down) next_state = rlss_pkg::rlss_state_e'(st_sd_entry);
            else if (sync_c_found_i) next_state = rlss_pkg::RLSS_DATA_FAST;
            else if (!rate_fast_i) next_state = rlss_pkg::RLSS_SYNC_SLOW;
         end
         rlss_pkg::RLSS_DATA_SLOW, rlss_pkg::RLSS_DATA_FAST: begin
            if (go_down) next_state = rlss_pkg::rlss_state_e'(st_sd_entry);
            else if (resync_i) next_state = rate_fast_i ?
               rlss_pkg::RLSS_SYNC_FAST : rlss_pkg::RLSS_SYNC_SLOW;
         end
         rlss_pkg::RLSS_SHUT_ONE: begin
            if (sd1_done) next_state = sd2_allow ? rlss_pkg::RLSS_SHUT_TWO
               : (wake ? rlss_pkg::RLSS_WARM : rlss_pkg::RLSS_OFF);
         end
         rlss_pkg::RLSS_SHUT_TWO: begin
            if (sd2_done) next_state = wake ? rlss_pkg::RLSS_WARM
               : rlss_pkg::RLSS_OFF;
         end
         default: next_state = rlss_pkg::RLSS_IDLE;
      endcase
   end

   // A wake request seen during shut-down waits for its end
   wire in_shut = (state == rlss_pkg::RLSS_SHUT_ONE) || (state == rlss_pkg::RLSS_SHUT_TWO);
   wire shut_to_warm = in_shut && (next_state == rlss_pkg::RLSS_WARM);
   wire shut_to_off  = (state != next_state) && (next_state == rlss_pkg::RLSS_OFF);

   // Leaving a state whose probe bit is set samples the battery input
   logic probe_here;
   always_comb begin
      probe_here = 1'b0;
      case (state)
         rlss_pkg::RLSS_SYNC_FAST: probe_here = fsync_probe;
         rlss_pkg::RLSS_SYNC_SLOW: probe_here = ssync_probe;
         rlss_pkg::RLSS_DATA_FAST: probe_here = fdata_probe;
         rlss_pkg::RLSS_DATA_SLOW: probe_here = sdata_probe;
         rlss_pkg::RLSS_SHUT_ONE:  probe_here = sd1_probe;
         rlss_pkg::RLSS_SHUT_TWO:  probe_here = sd2_probe;
         default:                  probe_here = 1'b0;
      endcase
   end
   wire take_batt = probe_here && state_chg;

   // Internal line pattern of the present state
   logic [7:0] int_lines;
   always_comb begin
      int_lines = off_pattern_i;
      case (state)
         rlss_pkg::RLSS_WARM:      int_lines = warmup_lines_i;
         rlss_pkg::RLSS_SYNC_FAST: int_lines = fsync_pat;
         rlss_pkg::RLSS_SYNC_SLOW: int_lines = ssync_pat;
         rlss_pkg::RLSS_DATA_FAST: int_lines = fdata_pat;
         rlss_pkg::RLSS_DATA_SLOW: int_lines = sdata_pat;
         rlss_pkg::RLSS_SHUT_ONE:  int_lines = sd1_pat;
         rlss_pkg::RLSS_SHUT_TWO:  int_lines = sd2_pat;
         default:                  int_lines = off_pattern_i;
      endcase
   end

   // Per-line override mux, one copy per control line
   logic [7:0] next_lines, next_oe;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_line
         assign next_lines[gi] = ovr_en[gi] ? ovr_lvl[gi] : int_lines[gi];
         assign next_oe[gi]    = ovr_en[gi] || ever_on;
      end
   endgenerate

   // Sequencer registers
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         state     <= rlss_pkg::RLSS_IDLE;
         en_q      <= 1'b0;
         ever_on   <= 1'b0;
         warm_pend <= 1'b0;
      end else begin
         state   <= next_state;
         en_q    <= decoder_enable_i;
         ever_on <= ever_on || en_rise;
         if (shut_to_warm || shut_to_off) warm_pend <= 1'b0;
         else if (in_shut && en_rise) warm_pend <= 1'b1;
      end
   end

   // Output registers
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         radio_ctrl_lines_o <= 8'h00;
         radio_ctrl_oe_o    <= 8'h00;
         warmup_start_o     <= 1'b0;
         dwell_done_o       <= 1'b0;
         battery_sample_o   <= 1'b0;
         battery_low_o      <= 1'b0;
      end else begin
         radio_ctrl_lines_o <= next_lines;
         radio_ctrl_oe_o    <= next_oe;
         warmup_start_o     <= state_chg && (next_state == rlss_pkg::RLSS_WARM);
         dwell_done_o       <= (state == rlss_pkg::RLSS_SYNC_FAST) && !state_chg && fs_done;
         battery_sample_o   <= take_batt;
         if (take_batt) battery_low_o <= battery_low_in_i;
      end
   end

   assign shutdown_busy_o = in_shut;
   assign state_o         = state;

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   // Line drive and override
   lines_follow_a: assert property (
      ovr_en[0] |=> radio_ctrl_lines_o[0] == $past(ovr_lvl[0]))
      else $error("override level not driven");
   float_idle_a: assert property (
      (!ever_on && ovr_en == 8'h00) |=> radio_ctrl_oe_o == 8'h00)
      else $error("lines driven before enable");
   ovr_float_a: assert property (
      !ever_on |=> radio_ctrl_oe_o == $past(ovr_en))
      else $error("override enables not followed before first enable");
   all_drive_a: assert property (
      ever_on |=> radio_ctrl_oe_o == 8'hff)
      else $error("line released after first enable");
   ovr_store_a: assert property (
      wr_ovr |=> ovr_en == $past(p_pat) && ovr_lvl == $past(p_lvl))
      else $error("override packet not stored");

   // Pattern of each state reaches the lines one cycle later
   fast_lines_a: assert property (
      (state == rlss_pkg::RLSS_SYNC_FAST && ovr_en == 8'h00)
      |=> radio_ctrl_lines_o == $past(fsync_pat))
      else $error("fast sync pattern not driven");
   data_lines_a: assert property (
      (state == rlss_pkg::RLSS_DATA_SLOW && ovr_en == 8'h00)
      |=> radio_ctrl_lines_o == $past(sdata_pat))
      else $error("slow data pattern not driven");
   shut_lines_a: assert property (
      (state == rlss_pkg::RLSS_SHUT_ONE && ovr_en == 8'h00)
      |=> radio_ctrl_lines_o == $past(sd1_pat))
      else $error("first step pattern not driven");
   off_lines_a: assert property (
      (state == rlss_pkg::RLSS_OFF && ovr_en == 8'h00)
      |=> radio_ctrl_lines_o == $past(off_pattern_i))
      else $error("off pattern not driven");

   // Sequencing
   sync_rate_a: assert property (
      (state == rlss_pkg::RLSS_SYNC_SLOW && rate_fast_i && !go_down && !sync_c_found_i)
      |=> state == rlss_pkg::RLSS_SYNC_FAST)
      else $error("sync pattern does not follow search rate");
   data_entry_a: assert property (
      (state == rlss_pkg::RLSS_SYNC_FAST && sync_c_found_i && !go_down)
      |=> state == rlss_pkg::RLSS_DATA_FAST)
      else $error("no data state after sync word");
   shut_skip_a: assert property (
      (is_on && go_down && !sd1_allow) |=> state == rlss_pkg::RLSS_OFF)
      else $error("disabled first step not skipped");
   stop_now_a: assert property (
      (is_on && !decoder_enable_i && sd1_allow) |=> state == rlss_pkg::RLSS_SHUT_ONE)
      else $error("enable clear did not start shut-down");
   step_len_a: assert property (
      (state == rlss_pkg::RLSS_SHUT_ONE && ticks < sd1_lim)
      |=> state == rlss_pkg::RLSS_SHUT_ONE)
      else $error("shut-down step left early");
   step_two_a: assert property (
      (state == rlss_pkg::RLSS_SHUT_ONE && sd1_done && !sd2_allow)
      |=> state != rlss_pkg::RLSS_SHUT_TWO)
      else $error("disabled second step entered");
   two_hold_a: assert property (
      (state == rlss_pkg::RLSS_SHUT_TWO && !sd2_done) |=> state == rlss_pkg::RLSS_SHUT_TWO)
      else $error("second shut-down step cut short");
   step_end_a: assert property (
      (state == rlss_pkg::RLSS_SHUT_TWO && sd2_done && !wake) |=> state == rlss_pkg::RLSS_OFF)
      else $error("off pattern not reached after last step");
   wake_after_a: assert property (
      (in_shut && wake) |=> state != rlss_pkg::RLSS_OFF)
      else $error("warm-up lost after shut-down");
   warm_pulse_a: assert property (
      (state_chg && next_state == rlss_pkg::RLSS_WARM)
      |=> warmup_start_o && state == rlss_pkg::RLSS_WARM)
      else $error("warm-up start not signalled");

   // Timing and stored fields
   dwell_wait_a: assert property (
      (state == rlss_pkg::RLSS_SYNC_FAST && !fs_done) |=> !dwell_done_o)
      else $error("dwell reported before its time");
   sd_store_a: assert property (
      wr_sd2 |=> sd2_allow == $past(p_allow) && sd2_dwell == $past(p_sdw))
      else $error("second step packet not stored");
   tick_gap_a: assert property (
      tick |=> !tick)
      else $error("tick period shorter than two cycles");

   // Battery sampling
   batt_take_a: assert property (
      (probe_here && state_chg)
      |=> battery_sample_o && battery_low_o == $past(battery_low_in_i))
      else $error("battery not sampled on exit");
   batt_quiet_a: assert property (
      !(probe_here && state_chg) |=> !battery_sample_o)
      else $error("battery sampled without a probed exit");

   fast_dwell_c: cover property (state == rlss_pkg::RLSS_SYNC_FAST ##1 dwell_done_o);
   two_steps_c:  cover property (state == rlss_pkg::RLSS_SHUT_TWO ##1 state == rlss_pkg::RLSS_OFF);
   rewarm_c:     cover property (in_shut ##1 state == rlss_pkg::RLSS_WARM);
   data_c:       cover property (state == rlss_pkg::RLSS_DATA_SLOW);
   skip_c:       cover property (is_on && go_down && !sd1_allow);

endmodule // rlss_top

// [testbench/rlss_radio_model.sv]
// Receiver front end model: resolves the control pins and supplies the battery input
`timescale 1ns/1ns

module rlss_radio_model (
   // Lines from the sequencer
   input  wire logic [7:0] radio_ctrl_lines_i,
   input  wire logic [7:0] radio_ctrl_oe_i,
   // Battery level chosen by the bench
   input  wire logic       battery_level_i,
   // Resolved pins and battery flag
   output logic [7:0]      pin_level_o,
   output logic            battery_low_in_o
);
   // Undriven pins sit on pull-downs, so a float never shows an old value
   assign pin_level_o      = radio_ctrl_lines_i & radio_ctrl_oe_i;
   assign battery_low_in_o = battery_level_i;
endmodule // rlss_radio_model

// [testbench/tb_top.sv]
// Self-checking bench for the radio line state sequencer
`timescale 1ns/1ns
`include "rlss_params.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
   localparam int TICK = 4;
   logic core_clk = 1'b0, rst_b = 1'b0, pkt_valid = 1'b0, dec_en = 1'b0, rate_fast = 1'b0;
   logic warm_done = 1'b0, sync_c = 1'b0, resync = 1'b0, off_req = 1'b0, bat_level = 1'b0;
   logic [7:0] pkt_id = 8'h00, warm_lines = 8'h3c, off_pat = 8'ha5, lines, oe, pins;
   logic [23:0] pkt_data = 24'h000000;
   logic       bat_in, warm_start, dwell_done, sd_busy, bat_sample, bat_low, seen;
   logic [3:0] state;
   logic [7:0] fp, sp, fdp, sdp, s1p, s2p;
   logic [5:0] d1, d2;
   logic [31:0] seed = 32'h0000000e;
   int error_cnt = 0, cmp_count = 0, n;

   // Clock at 10 MHz
   always #50 core_clk = ~core_clk;

   rlss_top #(.TICK_CYCLES(TICK)) DUT (
      .core_clk_i(core_clk), .rst_b_i(rst_b), .pkt_valid_i(pkt_valid), .pkt_id_i(pkt_id),
      .pkt_data_i(pkt_data), .decoder_enable_i(dec_en), .rate_fast_i(rate_fast),
      .warmup_done_i(warm_done), .warmup_lines_i(warm_lines), .sync_c_found_i(sync_c),
      .resync_i(resync), .rx_off_req_i(off_req), .off_pattern_i(off_pat),
      .battery_low_in_i(bat_in), .radio_ctrl_lines_o(lines), .radio_ctrl_oe_o(oe),
      .warmup_start_o(warm_start), .dwell_done_o(dwell_done), .shutdown_busy_o(sd_busy),
      .battery_sample_o(bat_sample), .battery_low_o(bat_low), .state_o(state));

   rlss_radio_model radio (
      .radio_ctrl_lines_i(lines), .radio_ctrl_oe_i(oe), .battery_level_i(bat_level),
      .pin_level_o(pins), .battery_low_in_o(bat_in));

   // Xorshift source, fixed start for repeatable runs
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Cycles spent in a shut-down step, dwell zero acts as one
   function automatic int exp_dwell(input logic [5:0] d);
      return ((d == 6'h00) ? 1 : int'(d)) * TICK + 1;
   endfunction

   task automatic stop_test();
      $display("errors %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Packet held one cycle; caller ends a burst with idle
   task automatic pkt(input logic [7:0] id, input logic [23:0] data);
      pkt_valid = 1'b1;
      pkt_id    = id;
      pkt_data  = data;
      @(negedge core_clk);
   endtask

   task automatic idle(input int c);
      pkt_valid = 1'b0;
      repeat (c) @(negedge core_clk);
   endtask

   // Bounded wait for a state; a miss counts as a mismatch
   task automatic wait_state(input rlss_pkg::rlss_state_e s, input int lim);
      n = 0;
      while (state !== s && n < lim) begin
         n++;
         @(negedge core_clk);
      end
      `CHK("state", s, state)
   endtask

   // Count cycles in a step and check its pattern once settled
   task automatic step_len(input rlss_pkg::rlss_state_e s, input logic [7:0] pat);
      n = 0;
      while (state === s && n < 600) begin
         n++;
         seen = seen | bat_sample;
         if (n == 2) `CHK("step_lines", pat, lines)
         @(negedge core_clk);
      end
   endtask

   task automatic pulse_warm(input logic fast);
      rate_fast = fast;
      warm_done = 1'b1;
      @(negedge core_clk);
      warm_done = 1'b0;
   endtask

   // Watchdog far beyond the expected few hundred cycles
   initial begin
      #(100 * 20000);
      error_cnt++;
      stop_test();
   end

   initial begin
      repeat (2) @(negedge core_clk);
      `CHK("oe_rst", 8'h00, oe)
      `CHK("pins_rst", 8'h00, pins)
      rst_b = 1'b1;
      idle(2);
      `CHK("state_idle", 4'(rlss_pkg::RLSS_IDLE), state)
      `CHK("oe_float", 8'h00, oe)
      // Override before first enable, then a stray ID
      pkt(`RLSS_ID_OVERRIDE, 24'h008101);
      pkt(8'h20, 24'hffffff);
      idle(2);
      `CHK("ovr_oe", 8'h81, oe)
      `CHK("ovr_pins", 8'h01, pins)
      pkt(`RLSS_ID_OVERRIDE, 24'h000000);
      idle(2);
      `CHK("ovr_clear", 8'h00, oe)
      // First enable with reset settings
      dec_en = 1'b1;
      wait_state(rlss_pkg::RLSS_WARM, 4);
      @(negedge core_clk);
      `CHK("warm_lines", warm_lines, lines)
      pulse_warm(1'b1);
      wait_state(rlss_pkg::RLSS_SYNC_FAST, 3);
      @(negedge core_clk);
      `CHK("fsync_rst", 8'h00, lines)
      off_req = 1'b1;
      @(negedge core_clk);
      off_req = 1'b0;
      `CHK("no_step", 4'(rlss_pkg::RLSS_OFF), state)
      @(negedge core_clk);
      `CHK("off_lines", off_pat, lines)
      // Random settings, sent back to back
      {fp, sp, fdp, sdp} = xs();
      {s1p, s2p, d1, d2} = 28'(xs());
      d1 = (d1 % 6'h03) + 6'h01;
      d2 = (d2 % 6'h03) + 6'h01;
      bat_level = xs() > 32'h7fffffff;
      pkt(`RLSS_ID_FAST_SYNC, {8'h08, fp, 8'h02});
      pkt(`RLSS_ID_SLOW_SYNC, {8'h00, sp, 8'h00});
      pkt(`RLSS_ID_FAST_DATA, {8'h00, fdp, 8'h00});
      pkt(`RLSS_ID_SLOW_DATA, {8'h00, sdp, 8'h00});
      pkt(`RLSS_ID_SHUT_ONE, {8'h88, s1p, 2'b00, d1});
      pkt(`RLSS_ID_SHUT_TWO, {8'h80, s2p, 2'b00, d2});
      dec_en = 1'b0;
      idle(1);
      dec_en = 1'b1;
      wait_state(rlss_pkg::RLSS_WARM, 4);
      pulse_warm(1'b1);
      wait_state(rlss_pkg::RLSS_SYNC_FAST, 3);
      @(negedge core_clk);
      `CHK("fsync_lines", fp, lines)
      n = 0;
      while (dwell_done !== 1'b1 && n < 2 * TICK + 4) begin
         n++;
         @(negedge core_clk);
      end
      `CHK("dwell_done", 1'b1, dwell_done)
      sync_c = 1'b1;
      @(negedge core_clk);
      sync_c = 1'b0;
      seen = bat_sample;
      @(negedge core_clk);
      seen = seen | bat_sample;
      `CHK("fsync_probe", 1'b1, seen)
      `CHK("bat_low", bat_level, bat_low)
      idle(20);
      `CHK("data_holds", 4'(rlss_pkg::RLSS_DATA_FAST), state)
      `CHK("fdata_lines", fdp, lines)
      resync = 1'b1;
      @(negedge core_clk);
      resync = 1'b0;
      `CHK("resync", 4'(rlss_pkg::RLSS_SYNC_FAST), state)
      sync_c = 1'b1;
      @(negedge core_clk);
      sync_c = 1'b0;
      // Two timed shut-down steps
      off_req = 1'b1;
      @(negedge core_clk);
      off_req = 1'b0;
      seen = 1'b0;
      step_len(rlss_pkg::RLSS_SHUT_ONE, s1p);
      `CHK("sd1_len", exp_dwell(d1), n)
      step_len(rlss_pkg::RLSS_SHUT_TWO, s2p);
      `CHK("sd2_len", exp_dwell(d2), n)
      `CHK("sd1_probe", 1'b1, seen)
      `CHK("after_sd", 4'(rlss_pkg::RLSS_OFF), state)
      // Slow path, override in data, enable drop and early re-enable
      dec_en = 1'b0;
      idle(1);
      dec_en = 1'b1;
      wait_state(rlss_pkg::RLSS_WARM, 4);
      pulse_warm(1'b0);
      wait_state(rlss_pkg::RLSS_SYNC_SLOW, 3);
      @(negedge core_clk);
      `CHK("ssync_lines", sp, lines)
      rate_fast = 1'b1;
      wait_state(rlss_pkg::RLSS_SYNC_FAST, 3);
      rate_fast = 1'b0;
      wait_state(rlss_pkg::RLSS_SYNC_SLOW, 3);
      sync_c = 1'b1;
      @(negedge core_clk);
      sync_c = 1'b0;
      @(negedge core_clk);
      `CHK("sdata_lines", sdp, lines)
      pkt(`RLSS_ID_OVERRIDE, 24'h000f05);
      idle(2);
      `CHK("ovr_data", (sdp & 8'hf0) | 8'h05, lines)
      pkt(`RLSS_ID_OVERRIDE, 24'h000000);
      idle(2);
      `CHK("ovr_back", sdp, lines)
      dec_en = 1'b0;
      @(negedge core_clk);
      `CHK("enable_drop", 4'(rlss_pkg::RLSS_SHUT_ONE), state)
      dec_en = 1'b1;
      seen = 1'b0;
      n = 0;
      while (state !== rlss_pkg::RLSS_WARM && n < 100) begin
         n++;
         seen = seen | !sd_busy;
         @(negedge core_clk);
      end
      `CHK("rewarm_len", exp_dwell(d1) + exp_dwell(d2), n)
      `CHK("busy_gap", 1'b0, seen)
      `CHK("warm_start", 1'b1, warm_start)
      // Reset in mid-run drops the override and floats every line
      pkt(`RLSS_ID_OVERRIDE, 24'h00ffff);
      rst_b = 1'b0;
      dec_en = 1'b0;
      idle(2);
      `CHK("oe_mid_rst", 8'h00, oe)
      `CHK("pins_mid_rst", 8'h00, pins)
      `CHK("state_mid_rst", 4'(rlss_pkg::RLSS_IDLE), state)
      rst_b = 1'b1;
      idle(2);
      `CHK("oe_after_rst", 8'h00, oe)
      stop_test();
   end
endmodule // tb_top
